// ==== cia_core.sv ====
// CPU slice: interrupt and trap entry, queue refill and the add group.
// Assumes a memory that answers bus reads combinationally in the same
// clock, and interrupt requests that are levels from same-clock logic.
//
// How it works
// - Pending interrupts are only taken at an instruction boundary.
// - Stacked program counter is the next instruction's address.
// - Interrupts share the trap sequence; vector latched at sequence start.
// - Stack order: PC low, PC high, index low, accumulator, condition codes.
// - Mask bit is set once the condition code byte is stacked.
// - Vector high byte is read first, then low byte.
// - One idle bus cycle follows the vector fetch.
// - Three program bytes from the vector refill the queue before execution.
// - Index high byte is never stacked during entry.
// - A service routine may clear the mask, allowing nesting.
// - Trap opcode enters the same path and ignores the mask.
// - Add-with-carry adds operand and carry, updates V H N Z C, 2 cycles.
// - Stack adjust adds sign-extended immediate to SP, flags unchanged.
// - Index adjust adds sign-extended immediate to index pair, no flags.
`timescale 1ns/1ps
`include "cia_params.svh"

module cia_core (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [`CIA_NIRQ-1:0] irq_req_in,
  input wire logic [7:0] bus_rdata_in,
  output logic [15:0] bus_addr_out,
  output logic bus_rd_out,
  output logic bus_wr_out,
  output logic [7:0] bus_wdata_out,
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out
);

  // ========================================================================
  // State
  cia_pkg::cia_core_s r_reg;
  cia_pkg::cia_core_s r_next;

  logic [15:0] irq_vec;
  logic irq_any;
  logic two_byte;
  logic [15:0] imm_sext;
  logic [15:0] hx_sum;
  logic [7:0] ccr_byte;
  cia_pkg::cia_alu_op_e alu_op;
  logic [7:0] alu_res;
  logic alu_v;
  logic alu_h;
  logic alu_n;
  logic alu_z;
  logic alu_c;
  wire logic [`CIA_NIRQ-1:0] irq_lower;
  wire logic [`CIA_NIRQ-1:0] irq_win;
  wire logic [`CIA_NIRQ-1:0][15:0] irq_vec_one;
  logic op_adc;
  logic op_add;
  logic op_and;
  logic op_sp_adj;
  logic op_idx_adj;
  logic op_trap;
  logic op_clr_mask;
  logic op_set_mask;
  logic take_irq;
  logic take_trap;
  logic at_boundary;
  logic in_entry;

  // ========================================================================
  // Arithmetic unit
  cia_alu u_alu (
    .op_in(alu_op),
    .a_in(r_reg.acc),
    .m_in(r_reg.q[1]),
    .c_in(r_reg.flag_c),
    .h_in(r_reg.flag_h),
    .res_out(alu_res),
    .v_out(alu_v),
    .h_out(alu_h),
    .n_out(alu_n),
    .z_out(alu_z),
    .c_out(alu_c)
  );

  // ========================================================================
  // Interrupt priority: lowest request index wins
  // A request wins only while no lower index is pending
  generate
    for (genvar gi = 0; gi < `CIA_NIRQ; gi++) begin : g_irq
      if (gi == 0) begin : g_first
        assign irq_lower[gi] = 1'b0;
      end else begin : g_rest
        assign irq_lower[gi] = irq_lower[gi-1] | irq_req_in[gi-1];
      end
      assign irq_win[gi] = irq_req_in[gi] & ~irq_lower[gi];
      assign irq_vec_one[gi] = irq_win[gi] ?
        (`CIA_IRQ_VEC_TOP - 16'(2 * gi)) : 16'h0000;
    end
  endgenerate

  // At most one winner, so an OR merges the candidates
  always_comb begin
    irq_any = |irq_req_in;
    irq_vec = 16'h0000;
    for (int i = 0; i < `CIA_NIRQ; i++) begin
      irq_vec = irq_vec | irq_vec_one[i];
    end
  end

  // ========================================================================
  // Opcode classes at the queue head
  always_comb begin
    op_adc = (r_reg.q[0] == `CIA_OP_ADC_IMM);
    op_add = (r_reg.q[0] == `CIA_OP_ADD_IMM);
    op_and = (r_reg.q[0] == `CIA_OP_AND_IMM);
    op_sp_adj = (r_reg.q[0] == `CIA_OP_SP_ADJ);
    op_idx_adj = (r_reg.q[0] == `CIA_OP_IDX_ADJ);
    op_trap = (r_reg.q[0] == `CIA_OP_TRAP);
    op_clr_mask = (r_reg.q[0] == `CIA_OP_CLR_MASK);
    op_set_mask = (r_reg.q[0] == `CIA_OP_SET_MASK);
    // Masked requests wait; the trap opcode ignores the mask
    take_irq = irq_any && !r_reg.flag_i;
    take_trap = op_trap;
    at_boundary = (r_reg.st == cia_pkg::ST_DECODE);
    in_entry = !at_boundary && (r_reg.st != cia_pkg::ST_EXEC2);
  end

  // ========================================================================
  // Decode helpers
  always_comb begin
    case (r_reg.q[0])
      `CIA_OP_ADC_IMM: alu_op = cia_pkg::ALU_ADC;
      `CIA_OP_AND_IMM: alu_op = cia_pkg::ALU_AND;
      default: alu_op = cia_pkg::ALU_ADD;
    endcase
    two_byte = op_adc || op_add || op_and || op_sp_adj || op_idx_adj;
    imm_sext = {{8{r_reg.q[1][7]}}, r_reg.q[1]};
    hx_sum = {r_reg.idx_hi, r_reg.idx_lo} + imm_sext;
    // Bits 6 and 5 of the condition byte always read as one
    ccr_byte = {r_reg.flag_v, 2'b11, r_reg.flag_h, r_reg.flag_i,
                r_reg.flag_n, r_reg.flag_z, r_reg.flag_c};
  end

  // ========================================================================
  // Next-state logic
  always_comb begin
    r_next = r_reg;

    // Register port
    r_next.reg_rdata = 8'h00;
    if (reg_rd_in) begin
      case (reg_addr_in)
        `CIA_REG_CTRL: r_next.reg_rdata = {7'h00, r_reg.halt};
        `CIA_REG_ACC: r_next.reg_rdata = r_reg.acc;
        `CIA_REG_IDX_LO: r_next.reg_rdata = r_reg.idx_lo;
        `CIA_REG_IDX_HI: r_next.reg_rdata = r_reg.idx_hi;
        `CIA_REG_SP_LO: r_next.reg_rdata = r_reg.sp[7:0];
        `CIA_REG_SP_HI: r_next.reg_rdata = r_reg.sp[15:8];
        `CIA_REG_PC_LO: r_next.reg_rdata = r_reg.pc[7:0];
        `CIA_REG_PC_HI: r_next.reg_rdata = r_reg.pc[15:8];
        `CIA_REG_CCR: r_next.reg_rdata = ccr_byte;
        `CIA_REG_STATUS: begin
          r_next.reg_rdata[`CIA_STAT_ENTRY_BIT] = in_entry;
          r_next.reg_rdata[`CIA_STAT_HALTED_BIT] =
            r_reg.halt && at_boundary;
        end
        default: r_next.reg_rdata = 8'h00;
      endcase
    end
    if (reg_wr_in && (reg_addr_in == `CIA_REG_CTRL)) begin
      r_next.halt = reg_wdata_in[`CIA_CTRL_HALT_BIT];
    end

    // Sequencer
    // Entry: five pushes, vector high, vector low, one free cycle,
    // then three refill reads; the reset path skips the pushes.
    case (r_reg.st)
      cia_pkg::ST_VEC_HI: begin
        r_next.pc[15:8] = bus_rdata_in;
        r_next.st = cia_pkg::ST_VEC_LO;
      end
      cia_pkg::ST_VEC_LO: begin
        r_next.pc[7:0] = bus_rdata_in;
        r_next.st = cia_pkg::ST_IDLE;
      end
      cia_pkg::ST_IDLE: begin
        r_next.cnt = 3'h0;
        r_next.st = cia_pkg::ST_FILL;
      end
      cia_pkg::ST_FILL: begin
        r_next.q[r_reg.cnt[1:0]] = bus_rdata_in;
        r_next.cnt = r_reg.cnt + 3'h1;
        if (r_reg.cnt == `CIA_FILL_LAST) begin
          r_next.st = cia_pkg::ST_DECODE;
        end
      end
      cia_pkg::ST_DECODE: begin
        // Only this state is a boundary, so no instruction is cut short
        if (r_reg.halt) begin
          r_next.st = cia_pkg::ST_DECODE;
        end else if (take_irq) begin
          r_next.save_pc = r_reg.pc;
          // Vector frozen here: a later, higher request cannot redirect
          r_next.vaddr = irq_vec;
          r_next.cnt = 3'h0;
          r_next.st = cia_pkg::ST_PUSH;
        end else if (take_trap) begin
          r_next.save_pc = r_reg.pc + 16'h0001;
          r_next.vaddr = `CIA_TRAP_VEC;
          r_next.cnt = 3'h0;
          r_next.st = cia_pkg::ST_PUSH;
        end else if (two_byte) begin
          r_next.b1 = bus_rdata_in;
          r_next.st = cia_pkg::ST_EXEC2;
        end else begin
          if (op_clr_mask) begin
            r_next.flag_i = 1'b0;
          end
          if (op_set_mask) begin
            r_next.flag_i = 1'b1;
          end
          // Other single-byte opcodes fall outside this slice: no effect
          r_next.q[0] = r_reg.q[1];
          r_next.q[1] = r_reg.q[2];
          r_next.q[2] = bus_rdata_in;
          r_next.pc = r_reg.pc + 16'h0001;
        end
      end
      cia_pkg::ST_EXEC2: begin
        case (r_reg.q[0])
          `CIA_OP_SP_ADJ: begin
            r_next.sp = r_reg.sp + imm_sext;
          end
          `CIA_OP_IDX_ADJ: begin
            r_next.idx_hi = hx_sum[15:8];
            r_next.idx_lo = hx_sum[7:0];
          end
          default: begin
            r_next.acc = alu_res;
            r_next.flag_v = alu_v;
            r_next.flag_h = alu_h;
            r_next.flag_n = alu_n;
            r_next.flag_z = alu_z;
            r_next.flag_c = alu_c;
          end
        endcase
        r_next.q[0] = r_reg.q[2];
        r_next.q[1] = r_reg.b1;
        r_next.q[2] = bus_rdata_in;
        r_next.pc = r_reg.pc + 16'h0002;
        r_next.st = cia_pkg::ST_DECODE;
      end
      cia_pkg::ST_PUSH: begin
        r_next.sp = r_reg.sp - 16'h0001;
        r_next.cnt = r_reg.cnt + 3'h1;
        if (r_reg.cnt == `CIA_PUSH_LAST) begin
          // Set after the last push, so the stacked copy keeps the old mask
          r_next.flag_i = 1'b1;
          r_next.st = cia_pkg::ST_VEC_HI;
        end
      end
      default: begin
        r_next.vaddr = `CIA_RESET_VEC;
        r_next.st = cia_pkg::ST_VEC_HI;
      end
    endcase

    // Bus request for the state being entered, so pins come from flops
    r_next.bus_rd = 1'b0;
    r_next.bus_wr = 1'b0;
    r_next.bus_wdata = 8'h00;
    r_next.bus_addr = r_reg.bus_addr;
    case (r_next.st)
      cia_pkg::ST_VEC_HI: begin
        r_next.bus_rd = 1'b1;
        r_next.bus_addr = r_next.vaddr;
      end
      cia_pkg::ST_VEC_LO: begin
        r_next.bus_rd = 1'b1;
        r_next.bus_addr = r_next.vaddr + 16'h0001;
      end
      cia_pkg::ST_IDLE: begin
        r_next.bus_rd = 1'b0;
      end
      cia_pkg::ST_FILL: begin
        r_next.bus_rd = 1'b1;
        r_next.bus_addr = r_next.pc + {13'h0000, r_next.cnt};
      end
      cia_pkg::ST_DECODE: begin
        // Prefetch is speculative; a taken interrupt simply drops it
        r_next.bus_rd = !r_next.halt;
        r_next.bus_addr = r_next.pc + `CIA_QUEUE_AHEAD;
      end
      cia_pkg::ST_EXEC2: begin
        r_next.bus_rd = 1'b1;
        r_next.bus_addr = r_next.pc + `CIA_QUEUE_AHEAD + 16'h0001;
      end
      cia_pkg::ST_PUSH: begin
        r_next.bus_wr = 1'b1;
        r_next.bus_addr = r_next.sp;
        // Index high byte deliberately absent from this list
        case (r_next.cnt)
          3'h0: r_next.bus_wdata = r_next.save_pc[7:0];
          3'h1: r_next.bus_wdata = r_next.save_pc[15:8];
          3'h2: r_next.bus_wdata = r_next.idx_lo;
          3'h3: r_next.bus_wdata = r_next.acc;
          default: r_next.bus_wdata = ccr_byte;
        endcase
      end
      default: begin
        r_next.bus_rd = 1'b0;
      end
    endcase
  end

  // ========================================================================
  // State register
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      r_reg <= '0;
      r_reg.st <= cia_pkg::ST_VEC_HI;
      r_reg.sp <= `CIA_SP_RESET;
      r_reg.flag_i <= 1'b1;
      r_reg.vaddr <= `CIA_RESET_VEC;
      r_reg.bus_addr <= `CIA_RESET_VEC;
      r_reg.bus_rd <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // ========================================================================
  // Outputs
  assign bus_addr_out = r_reg.bus_addr;
  assign bus_rd_out = r_reg.bus_rd;
  assign bus_wr_out = r_reg.bus_wr;
  assign bus_wdata_out = r_reg.bus_wdata;
  assign reg_rdata_out = r_reg.reg_rdata;

endmodule

// ==== cia_params.svh ====
// Constants for the interrupt-entry and add-group CPU slice.
// Assumes inclusion by the package, the core and the bench.
`ifndef CIA_PARAMS_SVH
`define CIA_PARAMS_SVH

// ==========================================================================
// Opcodes
`define CIA_OP_ADC_IMM 8'hA9
`define CIA_OP_ADD_IMM 8'hAB
`define CIA_OP_AND_IMM 8'hA4
`define CIA_OP_SP_ADJ 8'hA7
`define CIA_OP_IDX_ADJ 8'hAF
`define CIA_OP_TRAP 8'h83
`define CIA_OP_CLR_MASK 8'h9A
`define CIA_OP_SET_MASK 8'h9B

// ==========================================================================
// Vectors and reset values
`define CIA_RESET_VEC 16'hFFFE
`define CIA_TRAP_VEC 16'hFFFC
`define CIA_IRQ_VEC_TOP 16'hFFFA
`define CIA_NIRQ 8
`define CIA_SP_RESET 16'h00FF

// ==========================================================================
// Sequence counts
`define CIA_PUSH_LAST 3'h4
`define CIA_FILL_LAST 3'h2
`define CIA_QUEUE_AHEAD 16'h0003

// ==========================================================================
// Register port map and fields
`define CIA_REG_CTRL 4'h0
`define CIA_REG_ACC 4'h1
`define CIA_REG_IDX_LO 4'h2
`define CIA_REG_IDX_HI 4'h3
`define CIA_REG_SP_LO 4'h4
`define CIA_REG_SP_HI 4'h5
`define CIA_REG_PC_LO 4'h6
`define CIA_REG_PC_HI 4'h7
`define CIA_REG_CCR 4'h8
`define CIA_REG_STATUS 4'h9
`define CIA_CTRL_HALT_BIT 0
`define CIA_STAT_ENTRY_BIT 0
`define CIA_STAT_HALTED_BIT 1

`endif

// ==== cia_pkg.sv ====
// Types shared by the CPU slice: sequencer states, ALU operations and
// the packed state record of the core.
// Assumes cia_params.svh is on the include path.
`include "cia_params.svh"

package cia_pkg;

  // ========================================================================
  // Enumerations
  typedef enum logic [2:0] {
    ST_VEC_HI,
    ST_VEC_LO,
    ST_IDLE,
    ST_FILL,
    ST_DECODE,
    ST_EXEC2,
    ST_PUSH
  } cia_state_e;

  typedef enum logic [1:0] {
    ALU_ADD,
    ALU_ADC,
    ALU_AND
  } cia_alu_op_e;

  // ========================================================================
  // Core state record
  typedef struct packed {
    cia_state_e st;
    logic [2:0] cnt;
    logic [7:0] acc;
    logic [7:0] idx_lo;
    logic [7:0] idx_hi;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [2:0][7:0] q;
    logic flag_v;
    logic flag_h;
    logic flag_i;
    logic flag_n;
    logic flag_z;
    logic flag_c;
    logic [15:0] vaddr;
    logic [15:0] save_pc;
    logic [7:0] b1;
    logic halt;
    logic [15:0] bus_addr;
    logic bus_rd;
    logic bus_wr;
    logic [7:0] bus_wdata;
    logic [7:0] reg_rdata;
  } cia_core_s;

endpackage

// ==== cia_alu.sv ====
// Eight-bit add, add-with-carry and logical AND with flag results.
// Purely combinational; the caller decides which flags it keeps.
`timescale 1ns/1ps

module cia_alu (
  input wire cia_pkg::cia_alu_op_e op_in,
  input wire logic [7:0] a_in,
  input wire logic [7:0] m_in,
  input wire logic c_in,
  input wire logic h_in,
  output logic [7:0] res_out,
  output logic v_out,
  output logic h_out,
  output logic n_out,
  output logic z_out,
  output logic c_out
);

  logic [8:0] sum;
  logic [4:0] nib;
  logic cin;

  always_comb begin
    cin = (op_in == cia_pkg::ALU_ADC) ? c_in : 1'b0;
    sum = {1'b0, a_in} + {1'b0, m_in} + {8'h00, cin};
    nib = {1'b0, a_in[3:0]} + {1'b0, m_in[3:0]} + {4'h0, cin};
    if (op_in == cia_pkg::ALU_AND) begin
      res_out = a_in & m_in;
      v_out = 1'b0;
      h_out = h_in;
      c_out = c_in;
    end else begin
      res_out = sum[7:0];
      // Signed overflow: like-signed operands giving an unlike result
      v_out = (a_in[7] & m_in[7] & ~sum[7]) | (~a_in[7] & ~m_in[7] & sum[7]);
      h_out = nib[4];
      c_out = sum[8];
    end
    n_out = res_out[7];
    z_out = (res_out == 8'h00);
  end

endmodule

// ==== cia_core_chk.sv ====
// Checker for the CPU slice: entry stacking, vector fetch and refill.
// Assumes it is bound to cia_core and sees only its ports.
`timescale 1ns/1ps

module cia_core_chk (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [7:0] bus_rdata_in,
  input wire logic [15:0] bus_addr_out,
  input wire logic bus_rd_out,
  input wire logic bus_wr_out,
  input wire logic [7:0] bus_wdata_out,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  // ==========================================================================
  // Entry sequence
  stack_five_a: assert property ($rose(bus_wr_out) |->
    bus_wr_out [*5] ##1 !bus_wr_out) else $error("stack burst not five");
  stack_down_a: assert property (bus_wr_out && $past(bus_wr_out) |->
    bus_addr_out == $past(bus_addr_out) - 16'h0001)
    else $error("stack address not descending");
  ccr_last_a: assert property ($fell(bus_wr_out) |->
    ($past(bus_wdata_out) & 8'h60) == 8'h60)
    else $error("last stacked byte not condition codes");
  vec_pick_a: assert property ($fell(bus_wr_out) |->
    bus_rd_out && !bus_addr_out[0] && bus_addr_out >= 16'hFFEC &&
    bus_addr_out <= 16'hFFFC) else $error("vector high fetch wrong");
  vec_lo_a: assert property ($fell(bus_wr_out) |=>
    bus_rd_out && bus_addr_out == $past(bus_addr_out) + 16'h0001)
    else $error("vector low fetch wrong");
  idle_gap_a: assert property ($fell(bus_wr_out) |->
    ##2 !bus_rd_out && !bus_wr_out ##1 bus_rd_out)
    else $error("no single idle cycle after vector");
  fill_vec_a: assert property ($fell(bus_wr_out) |->
    ##3 bus_rd_out &&
    bus_addr_out == {$past(bus_rdata_in, 3), $past(bus_rdata_in, 2)}
    ##1 bus_rd_out && bus_addr_out == $past(bus_addr_out) + 16'h0001
    ##1 bus_rd_out && bus_addr_out == $past(bus_addr_out) + 16'h0001)
    else $error("queue refill not from vector");

  // ==========================================================================
  // Register port
  reg_quiet_a: assert property (!$past(reg_rd_in) |->
    reg_rdata_out == 8'h00) else $error("read data outside its cycle");
endmodule

bind cia_core cia_core_chk chk (.clk_in, .resetn_in, .bus_rdata_in,
  .bus_addr_out, .bus_rd_out, .bus_wr_out, .bus_wdata_out, .reg_rd_in,
  .reg_rdata_out);

// ==== cia_mem.sv ====
// Memory model for the CPU slice: combinational read, write on clock.
// Assumes the bench preloads m by hierarchical reference.
`timescale 1ns/1ps

module cia_mem (
  input wire logic clk_in,
  input wire logic rd_in,
  input wire logic wr_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out
);
  logic [7:0] m [0:65535] = '{default: 8'h00};
  logic [7:0] last_reg = 8'h00;

  // Idle bus shows the inverse of the last byte, never a stale copy
  assign rdata_out = rd_in ? m[addr_in] : ~last_reg;

  always @(posedge clk_in) begin
    if (wr_in) begin
      m[addr_in] <= wdata_in;
    end
    if (rd_in) begin
      last_reg <= m[addr_in];
    end
  end
endmodule

// ==== cia_core_tb.sv ====
// Testbench for the CPU slice: add group, interrupt entry and trap.
// Assumes cia_mem as memory; the halt bit single-steps the core.
`timescale 1ns/1ps
`include "cia_params.svh"

module cia_core_tb;
  logic clk_in;
  logic resetn_in;
  logic [`CIA_NIRQ-1:0] irq_req_in;
  logic [7:0] bus_rdata_in;
  logic [15:0] bus_addr_out;
  logic bus_rd_out;
  logic bus_wr_out;
  logic [7:0] bus_wdata_out;
  logic [3:0] reg_addr_in;
  logic [7:0] reg_wdata_in;
  logic reg_wr_in;
  logic reg_rd_in;
  logic [7:0] reg_rdata_out;
  logic [7:0] v;
  int n_fail = 0;
  int num_checks = 0;
  logic [7:0] prog [15] = '{8'hAB, 8'h7F, 8'hA9, 8'h01, 8'hAB, 8'h80,
    8'hA4, 8'hFF, 8'hA7, 8'hFE, 8'hAF, 8'h81, 8'hA9, 8'h00, 8'h9A};
  logic [7:0] a_t [8] = '{8'h7F, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h01, 8'h01};
  logic [7:0] c_t [8] = '{8'h68, 8'hFC, 8'hEB, 8'h6B, 8'h6B, 8'h6B,
    8'h68, 8'h60};
  logic [3:0] x_a [8] = '{4'h6, 4'h6, 4'h6, 4'h6, 4'h4, 4'h2, 4'h5, 4'h3};
  logic [7:0] x_v [8] = '{8'h02, 8'h04, 8'h06, 8'h08, 8'hFD, 8'h81,
    8'h00, 8'hFF};

  cia_core DUT (.clk_in, .resetn_in, .irq_req_in, .bus_rdata_in,
    .bus_addr_out, .bus_rd_out, .bus_wr_out, .bus_wdata_out, .reg_addr_in,
    .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out);
  cia_mem mem (.clk_in, .rd_in(bus_rd_out), .wr_in(bus_wr_out),
    .addr_in(bus_addr_out), .wdata_in(bus_wdata_out),
    .rdata_out(bus_rdata_in));

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  // ==========================================================================
  // Shared tasks
  task conclude;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task rd(input logic [3:0] a);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 v = reg_rdata_out;
  endtask

  task rc(input logic [3:0] a, input logic [7:0] e);
    rd(a);
    chk(v, e);
  endtask

  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask

  // Release and re-arm halt back to back: exactly one decode runs
  task step;
    @(posedge clk_in);
    reg_addr_in <= `CIA_REG_CTRL;
    reg_wdata_in <= 8'h00;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wdata_in <= 8'h01;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    for (int i = 0; i < 40; i++) begin
      rd(`CIA_REG_STATUS);
      if (v[1] === 1'b1) return;
    end
    n_fail++;
    conclude;
  endtask

  // ==========================================================================
  // Scenarios
  task t_reset;
    rc(`CIA_REG_PC_LO, 8'h00);
    rc(`CIA_REG_PC_HI, 8'h01);
    rc(`CIA_REG_SP_LO, 8'hFF);
    rc(`CIA_REG_CCR, 8'h68);
    rc(4'hF, 8'h00);
    rc(`CIA_REG_CTRL, 8'h01);
    rc(`CIA_REG_STATUS, 8'h02);
    wr(`CIA_REG_ACC, 8'h55);
    rc(`CIA_REG_ACC, 8'h00);
    $display("reset test done");
  endtask

  task t_alu;
    for (int i = 0; i < 8; i++) begin
      step;
      rc(`CIA_REG_ACC, a_t[i]);
      rc(`CIA_REG_CCR, c_t[i]);
      rc(x_a[i], x_v[i]);
    end
    $display("alu test done");
  endtask

  task t_irq;
    @(posedge clk_in);
    irq_req_in <= 8'h06;
    step;
    chk(mem.m[16'h00FD], 8'h0F);
    chk(mem.m[16'h00FC], 8'h01);
    chk(mem.m[16'h00FB], 8'h81);
    chk(mem.m[16'h00FA], 8'h01);
    chk(mem.m[16'h00F9], 8'h60);
    chk(mem.m[16'h00F8], 8'h5A);
    rc(`CIA_REG_PC_HI, 8'h02);
    rc(`CIA_REG_CCR, 8'h68);
    rc(`CIA_REG_IDX_HI, 8'hFF);
    step;
    rc(`CIA_REG_SP_LO, 8'hF8);
    step;
    step;
    rc(`CIA_REG_SP_LO, 8'hF3);
    chk(mem.m[16'h00F8], 8'h02);
    $display("interrupt test done");
  endtask

  task t_trap;
    @(posedge clk_in);
    irq_req_in <= 8'h00;
    repeat (4) step;
    rc(`CIA_REG_PC_HI, 8'h03);
    chk(mem.m[16'h00F3], 8'h04);
    chk(mem.m[16'h00EF] & 8'h08, 8'h08);
    rc(`CIA_REG_SP_LO, 8'hEE);
    $display("trap test done");
  endtask

  initial begin
    resetn_in = 1'b0;
    irq_req_in = 8'h00;
    reg_addr_in = 4'h0;
    reg_wdata_in = 8'h00;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    for (int i = 0; i < 15; i++) mem.m[16'h0100 + i] = prog[i];
    mem.m[16'hFFFE] = 8'h01;
    mem.m[16'hFFF8] = 8'h02;
    mem.m[16'hFFF6] = 8'h04;
    mem.m[16'hFFFC] = 8'h03;
    mem.m[16'h00F8] = 8'h5A;
    mem.m[16'h0201] = 8'h9A;
    mem.m[16'h0202] = 8'h9B;
    mem.m[16'h0203] = 8'h83;
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    wr(`CIA_REG_CTRL, 8'h01);
    repeat (8) @(posedge clk_in);
    t_reset;
    t_alu;
    t_irq;
    t_trap;
    conclude;
  end
endmodule
